// file: logic/sfeu_pkg.sv
// constants, field positions and codes shared by the vector fp exception unit
// assumes single-precision operands and one operation presented per cycle
package sfeu_pkg;

   localparam int FP_W  = 32;
   localparam int CSR_W = 16;
   localparam int EXC_N = 6;

   // control/status field positions
   localparam int BIT_INVALID_FLAG   = 0;
   localparam int BIT_SUBNORM_FLAG   = 1;
   localparam int BIT_ZDIV_FLAG      = 2;
   localparam int BIT_OVERFLOW_FLAG  = 3;
   localparam int BIT_UNDERFLOW_FLAG = 4;
   localparam int BIT_PRECISION_FLAG = 5;
   localparam int BIT_DAZ            = 6;
   localparam int BIT_INVALID_MASK   = 7;
   localparam int BIT_SUBNORM_MASK   = 8;
   localparam int BIT_ZDIV_MASK      = 9;
   localparam int BIT_OVERFLOW_MASK  = 10;
   localparam int BIT_UNDERFLOW_MASK = 11;
   localparam int BIT_PRECISION_MASK = 12;
   localparam int BIT_FTZ            = 15;
   localparam int FLAG_LO            = BIT_INVALID_FLAG;
   localparam int MASK_LO            = BIT_INVALID_MASK;

   localparam logic [CSR_W-1:0] CSR_RESET = 16'h1F80;

   // single-precision layout
   localparam int FP_SIGN  = 31;
   localparam int EXP_HI   = 30;
   localparam int EXP_LO   = 23;
   localparam int FRAC_HI  = 22;
   localparam int QUIET_BIT = 22;
   localparam logic [7:0]       EXP_ONES   = 8'hFF;
   localparam logic [7:0]       EXP_ZERO   = 8'h00;
   localparam logic [22:0]      FRAC_ZERO  = 23'h00_0000;
   localparam logic [FP_W-1:0]  QNAN_INDEF = 32'hFFC0_0000;
   localparam logic [FP_W-1:0]  INT_INDEF  = 32'h8000_0000;
   localparam logic [FP_W-1:0]  MASK_ONES  = 32'hFFFF_FFFF;
   localparam logic [FP_W-1:0]  MASK_ZERO  = 32'h0000_0000;

   // arithmetic status pattern for an unordered compare (zero, parity, carry)
   localparam logic [2:0] ARITH_UNORDERED = 3'h7;

   typedef enum logic [3:0] {
      OP_ADD     = 4'h0,
      OP_SUB     = 4'h1,
      OP_MUL     = 4'h2,
      OP_DIV     = 4'h3,
      OP_ADDSUB  = 4'h4,
      OP_HADD    = 4'h5,
      OP_HSUB    = 4'h6,
      OP_SQRT    = 4'h7,
      OP_MAX     = 4'h8,
      OP_MIN     = 4'h9,
      OP_CMP     = 4'hA,
      OP_CVT_FP  = 4'hB,
      OP_COMI    = 4'hC,
      OP_CVT_INT = 4'hD,
      OP_FIST    = 4'hE,
      OP_OTHER   = 4'hF
   } sfeu_op_t;

   typedef enum logic [2:0] {
      PRED_EQ    = 3'h0,
      PRED_LT    = 3'h1,
      PRED_LE    = 3'h2,
      PRED_UNORD = 3'h3,
      PRED_NEQ   = 3'h4,
      PRED_NLT   = 3'h5,
      PRED_NLE   = 3'h6,
      PRED_ORD   = 3'h7
   } sfeu_pred_t;

endpackage

// file: logic/sfeu_fp_class.sv
// classifies one single-precision operand and forms its quieted copy
// assumes a purely combinational use by the exception unit
`timescale 1ns/1ps
module sfeu_fp_class
   import sfeu_pkg::*;
(
   input  wire logic [FP_W-1:0] i_val,
   output logic                 o_nan,
   output logic                 o_snan,
   output logic                 o_inf,
   output logic                 o_zero,
   output logic                 o_sign,
   output logic [FP_W-1:0]      o_quiet
);
   wire logic exp_ones  = (i_val[EXP_HI:EXP_LO] == EXP_ONES);
   wire logic exp_zero  = (i_val[EXP_HI:EXP_LO] == EXP_ZERO);
   wire logic frac_zero = (i_val[FRAC_HI:0] == FRAC_ZERO);

   assign o_nan   = exp_ones & ~frac_zero;
   assign o_snan  = o_nan & ~i_val[QUIET_BIT];
   assign o_inf   = exp_ones & frac_zero;
   assign o_zero  = exp_zero & frac_zero;
   assign o_sign  = i_val[FP_SIGN];
   assign o_quiet = i_val | (FP_W'(1) << QUIET_BIT);
endmodule

// file: logic/sfeu_exc_unit.sv
// vector floating-point exception unit: detection, masked response, flags, faults
// assumes the datapath presents one completed operation per cycle with its
// other-class conditions already detected; software loads/stores the csr
//
// Notes on behaviour
// - six exception classes are kept apart
// - fault reported together with o_done, the cycle after the op is taken
// - each class has sticky flag and mask
// - masks written by load; all read back
// - unmasked with os enable raises vector fault
// - os enable clear raises undefined-opcode fault
// - invalid flag bit 0, mask bit 7
// - masked response overwrites the destination register
// - arithmetic signalling nan returns quieted nan
// - sqrt snan quieted; negative gives indefinite
// - max/min with nan returns second source
// - compare nan gives zeros, four predicates ones
// - precision conversion snan returns quieted nan
// - ordered compare nan sets unordered status
// - infinity and zero misuse returns indefinite
// - bad integer conversion returns integer indefinite
// - unmasked invalid faults, leaves operands untouched
// - quiet nan alone raises invalid only for compares and integer conversion
// - ordered and four predicate compares trap qnan
// - invalid ignores flush and denormal controls
// - truncating integer store raises no vector exception
// - subnormal flag bit 1, mask 8
// - zero-divide flag bit 2, mask 9
// - overflow flag bit 3, mask 10
// - underflow flag bit 4, mask 11
`timescale 1ns/1ps
module sfeu_exc_unit
   import sfeu_pkg::*;
(
   input  wire logic               i_clk_sys,
   input  wire logic               i_rst_n,
   input  wire logic               i_ce,
   input  wire logic               i_op_valid,
   input  wire logic [3:0]         i_op,
   input  wire logic [2:0]         i_pred,
   input  wire logic [FP_W-1:0]    i_src1,
   input  wire logic [FP_W-1:0]    i_src2,
   input  wire logic [FP_W-1:0]    i_nominal,
   input  wire logic               i_int_range_err,
   input  wire logic [4:0]         i_other_exc,
   input  wire logic               i_os_vector_handler_enable,
   input  wire logic               i_csr_wr,
   input  wire logic [CSR_W-1:0]   i_csr_wdata,
   output logic [CSR_W-1:0]        o_vector_fp_ctrl_status,
   output logic                    o_done,
   output logic [FP_W-1:0]         o_result,
   output logic                    o_result_we,
   output logic [2:0]              o_arith_status_flags,
   output logic                    o_arith_status_we,
   output logic                    o_vector_fp_fault,
   output logic                    o_undefined_opcode_fault,
   output logic [EXC_N-1:0]        o_exc_detected
);

   // operand classification
   logic [1:0]            c_nan, c_snan, c_inf, c_zero, c_sign;
   logic [FP_W-1:0]       c_quiet [2];
   wire logic [FP_W-1:0]  src [2];
   assign src[0] = i_src1;
   assign src[1] = i_src2;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_cls
         sfeu_fp_class u_cls (
            .i_val   (src[g]),
            .o_nan   (c_nan[g]),
            .o_snan  (c_snan[g]),
            .o_inf   (c_inf[g]),
            .o_zero  (c_zero[g]),
            .o_sign  (c_sign[g]),
            .o_quiet (c_quiet[g])
         );
      end
   endgenerate

   function automatic logic f_arith(input logic [3:0] op);
      case (op)
         OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_ADDSUB, OP_HADD, OP_HSUB: f_arith = 1'b1;
         default: f_arith = 1'b0;
      endcase
   endfunction

   function automatic logic f_add_like(input logic [3:0] op);
      f_add_like = (op == OP_ADD) | (op == OP_ADDSUB) | (op == OP_HADD);
   endfunction

   // state
   logic [CSR_W-1:0] csr_q, csr_d;
   logic [FP_W-1:0]  res_q;
   logic [2:0]       aflag_q;
   logic             done_q, res_we_q, aflag_we_q, vfault_q, udfault_q;
   logic [EXC_N-1:0] exc_q;

   wire logic take     = i_ce & i_op_valid;
   wire logic is_fist  = (i_op == OP_FIST);
   wire logic any_nan  = |c_nan;
   wire logic any_snan = |c_snan;
   wire logic two_op   = (i_op != OP_SQRT) & (i_op != OP_CVT_FP) & (i_op != OP_CVT_INT);
   wire logic nan_in   = c_nan[0] | (two_op & c_nan[1]);
   wire logic snan_in  = c_snan[0] | (two_op & c_snan[1]);

   // invalid detection; daz/ftz bits never enter these terms
   wire logic pred_qtrap = (i_pred == PRED_LT) | (i_pred == PRED_LE) |
                           (i_pred == PRED_NLT) | (i_pred == PRED_NLE);
   wire logic pred_ones  = (i_pred == PRED_NEQ) | (i_pred == PRED_UNORD) |
                           (i_pred == PRED_NLT) | (i_pred == PRED_NLE);
   wire logic inv_snan   = snan_in & (f_arith(i_op) | (i_op == OP_SQRT) | (i_op == OP_MAX) |
                           (i_op == OP_MIN) | (i_op == OP_CMP) | (i_op == OP_CVT_FP) |
                           (i_op == OP_COMI));
   wire logic inv_qnan   = any_nan & ((i_op == OP_COMI) | ((i_op == OP_CMP) & pred_qtrap));
   wire logic sign_diff  = c_sign[0] ^ c_sign[1];
   wire logic inf_add    = (&c_inf) & ((f_add_like(i_op) & sign_diff) |
                           (~f_add_like(i_op) & f_arith(i_op) & (i_op != OP_MUL) &
                            (i_op != OP_DIV) & ~sign_diff));
   wire logic inf_mul    = (i_op == OP_MUL) & ((c_inf[0] & c_zero[1]) | (c_zero[0] & c_inf[1]));
   wire logic inf_div    = (i_op == OP_DIV) & ((&c_zero) | (&c_inf));
   wire logic sqrt_neg   = (i_op == OP_SQRT) & c_sign[0] & ~c_nan[0] & ~c_zero[0];
   wire logic cvt_bad    = (i_op == OP_CVT_INT) & (c_nan[0] | c_inf[0] | i_int_range_err);
   wire logic indef      = ~snan_in & (inf_add | inf_mul | inf_div | sqrt_neg);
   wire logic invalid    = inv_snan | inv_qnan | indef | cvt_bad;

   // six separate event classes; truncating integer store reports none
   wire logic [EXC_N-1:0] events = is_fist ? '0 : {i_other_exc[4], i_other_exc[3],
                                   i_other_exc[2], i_other_exc[1], i_other_exc[0],
                                   invalid};
   wire logic [EXC_N-1:0] masks    = csr_q[MASK_LO +: EXC_N];
   wire logic [EXC_N-1:0] unmasked = events & ~masks;
   wire logic             fault    = |unmasked;

   // masked response selection
   wire logic [FP_W-1:0] snan_q  = c_snan[0] ? c_quiet[0] : c_quiet[1];
   wire logic [FP_W-1:0] cmp_val = pred_ones ? MASK_ONES : MASK_ZERO;
   logic [FP_W-1:0] resp;
   always_comb begin
      resp = i_nominal;
      if (is_fist) begin
         resp = i_nominal;
      end else if ((i_op == OP_MAX) | (i_op == OP_MIN)) begin
         if (nan_in) resp = i_src2;
      end else if (i_op == OP_CMP) begin
         if (nan_in) resp = cmp_val;
      end else if (cvt_bad) begin
         resp = INT_INDEF;
      end else if (inv_snan & (f_arith(i_op) | (i_op == OP_SQRT) | (i_op == OP_CVT_FP))) begin
         resp = snan_q;
      end else if (indef) begin
         resp = QNAN_INDEF;
      end
   end

   wire logic writes_dest = (i_op != OP_COMI) & (i_op != OP_OTHER);
   wire logic do_write    = ~fault & writes_dest;
   wire logic do_status   = ~fault & (i_op == OP_COMI);

   // csr: software load replaces, detected events set; set wins over clear
   always_comb begin
      csr_d = i_csr_wr ? i_csr_wdata : csr_q;
      if (take) begin
         csr_d[FLAG_LO +: EXC_N] = csr_d[FLAG_LO +: EXC_N] | events;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         csr_q <= CSR_RESET;
      end else if (i_ce) begin
         csr_q <= csr_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         done_q     <= 1'b0;
         res_we_q   <= 1'b0;
         aflag_we_q <= 1'b0;
         vfault_q   <= 1'b0;
         udfault_q  <= 1'b0;
         exc_q      <= '0;
      end else if (i_ce) begin
         done_q     <= i_op_valid;
         res_we_q   <= i_op_valid & do_write;
         aflag_we_q <= i_op_valid & do_status;
         vfault_q   <= i_op_valid & fault & i_os_vector_handler_enable;
         udfault_q  <= i_op_valid & fault & ~i_os_vector_handler_enable;
         exc_q      <= i_op_valid ? events : '0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         res_q   <= '0;
         aflag_q <= '0;
      end else if (take) begin
         res_q   <= resp;
         aflag_q <= nan_in ? ARITH_UNORDERED : i_nominal[2:0];
      end
   end

   assign o_vector_fp_ctrl_status  = csr_q;
   assign o_done                   = done_q;
   assign o_result                 = res_q;
   assign o_result_we              = res_we_q;
   assign o_arith_status_flags     = aflag_q;
   assign o_arith_status_we        = aflag_we_q;
   assign o_vector_fp_fault        = vfault_q;
   assign o_undefined_opcode_fault = udfault_q;
   assign o_exc_detected           = exc_q;

   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   property p_precise;
      take |=> o_done;
   endproperty
   a_precise: assert property (p_precise) else $error("completion not reported");

   property p_vec_fault;
      take & fault & i_os_vector_handler_enable |=> o_vector_fp_fault & !o_undefined_opcode_fault;
   endproperty
   a_vec_fault: assert property (p_vec_fault) else $error("vector fault missing");

   property p_undef_fault;
      take & fault & !i_os_vector_handler_enable |=> o_undefined_opcode_fault & !o_vector_fp_fault;
   endproperty
   a_undef_fault: assert property (p_undef_fault) else $error("undefined fault missing");

   property p_no_write_on_fault;
      (o_vector_fp_fault | o_undefined_opcode_fault) |-> !o_result_we && !o_arith_status_we;
   endproperty
   a_no_write_on_fault: assert property (p_no_write_on_fault) else $error("write on fault");

   property p_sticky;
      i_ce & !i_csr_wr |=> ((csr_q[FLAG_LO +: EXC_N] & $past(csr_q[FLAG_LO +: EXC_N])) ==
                            $past(csr_q[FLAG_LO +: EXC_N]));
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");

   property p_invalid_flag;
      take & !is_fist & invalid |=> csr_q[BIT_INVALID_FLAG] && o_exc_detected[BIT_INVALID_FLAG];
   endproperty
   a_invalid_flag: assert property (p_invalid_flag) else $error("invalid flag not set");

   property p_fist_quiet;
      take & is_fist & !i_csr_wr |=> !o_vector_fp_fault && !o_undefined_opcode_fault &&
                                     csr_q == $past(csr_q);
   endproperty
   a_fist_quiet: assert property (p_fist_quiet) else $error("store raised exception");

   property p_sqrt_indef;
      take & (i_op == OP_SQRT) & c_sign[0] & !c_nan[0] & !c_zero[0] & !fault
         |=> o_result_we && o_result == QNAN_INDEF;
   endproperty
   a_sqrt_indef: assert property (p_sqrt_indef) else $error("sqrt indefinite wrong");

   property p_comi_unord;
      take & (i_op == OP_COMI) & nan_in & !fault
         |=> o_arith_status_we && o_arith_status_flags == ARITH_UNORDERED;
   endproperty
   a_comi_unord: assert property (p_comi_unord) else $error("unordered status wrong");

   property p_qnan_add_quiet;
      take & (i_op == OP_ADD) & nan_in & !snan_in |-> !invalid;
   endproperty
   a_qnan_add_quiet: assert property (p_qnan_add_quiet) else $error("qnan raised invalid");

   property p_hold;
      !i_ce |=> $stable(csr_q) && $stable(o_done) && $stable(o_result) && $stable(o_exc_detected);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved while enable low");

   property p_csr_load;
      i_ce & i_csr_wr & !take |=> o_vector_fp_ctrl_status == $past(i_csr_wdata);
   endproperty
   a_csr_load: assert property (p_csr_load) else $error("csr load lost");

   property p_minmax_src2;
      take & ((i_op == OP_MAX) | (i_op == OP_MIN)) & nan_in & !fault
         |=> o_result_we && o_result == $past(i_src2);
   endproperty
   a_minmax_src2: assert property (p_minmax_src2) else $error("max min nan response wrong");

   property p_mul_indef;
      take & (i_op == OP_MUL) & ((c_inf[0] & c_zero[1]) | (c_zero[0] & c_inf[1])) & !fault
         |=> o_result_we && o_result == QNAN_INDEF;
   endproperty
   a_mul_indef: assert property (p_mul_indef) else $error("inf times zero response wrong");

   property p_cvt_indef;
      take & (i_op == OP_CVT_INT) & (c_nan[0] | c_inf[0] | i_int_range_err) & !fault
         |=> o_result_we && o_result == INT_INDEF;
   endproperty
   a_cvt_indef: assert property (p_cvt_indef) else $error("integer indefinite missing");

   property p_qnan_trap;
      take & nan_in & ((i_op == OP_COMI) | ((i_op == OP_CMP) & pred_qtrap))
         |=> o_exc_detected[BIT_INVALID_FLAG];
   endproperty
   a_qnan_trap: assert property (p_qnan_trap) else $error("quiet nan compare not trapped");

   c_vec_fault: cover property (take & fault & i_os_vector_handler_enable ##1 o_vector_fp_fault);
   c_undef:     cover property (take & fault & !i_os_vector_handler_enable ##1 o_undefined_opcode_fault);
   c_masked:    cover property (take & invalid & !fault ##1 o_result_we);
   c_csr_load:  cover property (i_ce & i_csr_wr ##1 o_vector_fp_ctrl_status == $past(i_csr_wdata));
   c_hold:      cover property (!i_ce & i_op_valid & i_csr_wr);

endmodule

// file: verif/sfeu_handler_model.sv
// software handler model: counts delivered vector faults and undefined-opcode faults
// assumes both faults are one-cycle pulses in the core clock domain
`timescale 1ns/1ps
module sfeu_handler_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic       i_vector_fp_fault,
   input  wire logic       i_undefined_opcode_fault,
   output logic [7:0]      o_vec_cnt,
   output logic [7:0]      o_ud_cnt
);
   // each pulse stands for one handler entry
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_vec_cnt <= 8'h00;
         o_ud_cnt  <= 8'h00;
      end else begin
         if (i_vector_fp_fault === 1'h1) begin
            o_vec_cnt <= o_vec_cnt + 8'h01;
         end
         if (i_undefined_opcode_fault === 1'h1) begin
            o_ud_cnt <= o_ud_cnt + 8'h01;
         end
      end
   end
endmodule

// file: verif/simd_fp_exception_unit_tb_top.sv
// self-checking bench for the vector fp exception unit
// assumes the handler model beside it and a 4 ns core clock
`timescale 1ns/1ps
module simd_fp_exception_unit_tb_top
   import sfeu_pkg::*;
   ;
   localparam logic [31:0] SN = 32'h7F80_0001, SQ = 32'h7FC0_0001, QN = 32'h7FC0_0000;
   localparam logic [31:0] ONE = 32'h3F80_0000, INF = 32'h7F80_0000, NINF = 32'hFF80_0000;
   logic             clk_sys = 1'h0, rst_n = 1'h0, op_valid = 1'h0, rng = 1'h0, ce = 1'h1;
   logic             os_en = 1'h1, csr_wr = 1'h0, done, res_we, ar_we, vfault, udfault;
   logic [3:0]       op = 4'h0;
   logic [2:0]       pred = 3'h0, arith;
   logic [4:0]       other = 5'h00;
   logic [31:0]      src1 = 32'h0000_0000, src2 = 32'h0000_0000, nominal = 32'h0000_0000;
   logic [31:0]      result;
   logic [15:0]      wdata = 16'h0000, csr;
   logic [5:0]       exc;
   logic [7:0]       vec_cnt, ud_cnt;
   int               error_cnt = 0, tests_run = 0, cyc = 0;

   always #2 clk_sys = ~clk_sys;

   sfeu_exc_unit dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_ce(ce), .i_op_valid(op_valid),
      .i_op(op), .i_pred(pred), .i_src1(src1), .i_src2(src2), .i_nominal(nominal),
      .i_int_range_err(rng), .i_other_exc(other), .i_os_vector_handler_enable(os_en),
      .i_csr_wr(csr_wr), .i_csr_wdata(wdata), .o_vector_fp_ctrl_status(csr), .o_done(done),
      .o_result(result), .o_result_we(res_we), .o_arith_status_flags(arith),
      .o_arith_status_we(ar_we), .o_vector_fp_fault(vfault),
      .o_undefined_opcode_fault(udfault), .o_exc_detected(exc));

   sfeu_handler_model handler (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_vector_fp_fault(vfault),
      .i_undefined_opcode_fault(udfault), .o_vec_cnt(vec_cnt), .o_ud_cnt(ud_cnt));

   task report_and_stop;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         $display("Error timeout expected under %0d cycles seen %0d", 3000, cyc);
         error_cnt++;
         report_and_stop();
      end
   end

   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", name, e, g);
         error_cnt++;
      end
   endtask

   task chkb(input string name, input logic e, input logic g);
      chk(name, {31'h0000_0000, e}, {31'h0000_0000, g});
   endtask

   task csr_write(input logic [15:0] d);
      @(posedge clk_sys);
      csr_wr <= 1'h1;
      wdata <= d;
      @(posedge clk_sys);
      csr_wr <= 1'h0;
      #1;
      chk("csr", {16'h0000, d}, {16'h0000, csr});
   endtask

   task do_op(input sfeu_op_t o, input logic [2:0] p, input logic [31:0] a, b, n,
              input logic [4:0] oe, input logic r);
      @(posedge clk_sys);
      op <= o;
      pred <= p;
      src1 <= a;
      src2 <= b;
      nominal <= n;
      other <= oe;
      rng <= r;
      op_valid <= 1'h1;
      @(posedge clk_sys);
      op_valid <= 1'h0;
      other <= 5'h00;
      rng <= 1'h0;
      #1;
      chkb("done", 1'h1, done);
   endtask

   task masked(input sfeu_op_t o, input logic [2:0] p, input logic [31:0] a, b, n,
               input logic r, input logic [31:0] er, input logic ei);
      do_op(o, p, a, b, n, 5'h00, r);
      chk("result", er, result);
      chkb("result_we", 1'h1, res_we);
      chk("exc", {26'h000_0000, 5'h00, ei}, {26'h000_0000, exc});
   endtask

   task t_reset;
      chk("csr", 32'h0000_1F80, {16'h0000, csr});
      chkb("vfault", 1'h0, vfault);
   endtask

   task t_masked_table;
      sfeu_op_t ar [7];
      ar = '{OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_ADDSUB, OP_HADD, OP_HSUB};
      for (int k = 0; k < 7; k++) begin
         masked(ar[k], 3'h0, SN, ONE, ONE, 1'h0, SQ, 1'h1);
      end
      masked(OP_SQRT, 3'h0, SN, ONE, ONE, 1'h0, SQ, 1'h1);
      masked(OP_SQRT, 3'h0, 32'hC000_0000, ONE, ONE, 1'h0, QNAN_INDEF, 1'h1);
      masked(OP_MAX, 3'h0, SN, ONE, ONE, 1'h0, ONE, 1'h1);
      masked(OP_MIN, 3'h0, QN, ONE, QN, 1'h0, ONE, 1'h0);
      masked(OP_CVT_FP, 3'h0, SN, ONE, ONE, 1'h0, SQ, 1'h1);
      masked(OP_ADD, 3'h0, INF, NINF, ONE, 1'h0, QNAN_INDEF, 1'h1);
      masked(OP_SUB, 3'h0, INF, INF, ONE, 1'h0, QNAN_INDEF, 1'h1);
      masked(OP_MUL, 3'h0, INF, 32'h0000_0000, ONE, 1'h0, QNAN_INDEF, 1'h1);
      masked(OP_DIV, 3'h0, 32'h0000_0000, 32'h0000_0000, ONE, 1'h0, QNAN_INDEF, 1'h1);
      masked(OP_DIV, 3'h0, INF, INF, ONE, 1'h0, QNAN_INDEF, 1'h1);
      masked(OP_CVT_INT, 3'h0, QN, ONE, ONE, 1'h0, INT_INDEF, 1'h1);
      masked(OP_CVT_INT, 3'h0, 32'h4F80_0000, ONE, ONE, 1'h1, INT_INDEF, 1'h1);
      masked(OP_ADD, 3'h0, QN, ONE, QN, 1'h0, QN, 1'h0);
      chkb("invalid_flag", 1'h1, csr[0]);
   endtask

   task t_compare;
      logic [31:0] em;
      for (int p = 0; p < 8; p++) begin
         em = (p >= 3 && p <= 6) ? MASK_ONES : MASK_ZERO;
         masked(OP_CMP, 3'(p), QN, ONE, ONE, 1'h0, em, p inside {1, 2, 5, 6});
      end
      do_op(OP_COMI, 3'h0, ONE, QN, ONE, 5'h00, 1'h0);
      chk("arith", 32'h0000_0007, {29'h0000_0000, arith});
      chkb("arith_we", 1'h1, ar_we);
      chkb("result_we", 1'h0, res_we);
      chk("exc", 32'h0000_0001, {26'h000_0000, exc});
   endtask

   task t_unmasked;
      csr_write(16'h0000);
      do_op(OP_FIST, 3'h0, SN, SN, 32'h0000_0005, 5'h1F, 1'h0);
      chk("exc", 32'h0000_0000, {26'h000_0000, exc});
      chkb("vfault", 1'h0, vfault | udfault);
      chk("result", 32'h0000_0005, result);
      do_op(OP_SQRT, 3'h0, 32'hC000_0000, ONE, ONE, 5'h00, 1'h0);
      chkb("vfault", 1'h1, vfault);
      chkb("udfault", 1'h0, udfault);
      chkb("result_we", 1'h0, res_we);
      @(posedge clk_sys);
      os_en <= 1'h0;
      do_op(OP_SQRT, 3'h0, 32'hC000_0000, ONE, ONE, 5'h00, 1'h0);
      chkb("udfault", 1'h1, udfault);
      chkb("vfault", 1'h0, vfault);
      @(posedge clk_sys);
      os_en <= 1'h1;
      for (int k = 0; k < 5; k++) begin
         csr_write(16'h1F80);
         do_op(OP_ADD, 3'h0, ONE, ONE, ONE, 5'(1 << k), 1'h0);
         chk("exc", 32'(2 << k), {26'h000_0000, exc});
         chkb("vfault", 1'h0, vfault);
         chkb("flag", 1'h1, csr[k + 1]);
         csr_write(16'h1F80 & ~(16'h0100 << k));
         do_op(OP_ADD, 3'h0, ONE, ONE, ONE, 5'(1 << k), 1'h0);
         chkb("vfault", 1'h1, vfault);
      end
      // the handler counts the last pulse at the edge after it is seen
      @(posedge clk_sys);
      #1;
      chk("vec_cnt", 32'h0000_0006, {24'h00_0000, vec_cnt});
      chk("ud_cnt", 32'h0000_0001, {24'h00_0000, ud_cnt});
   endtask

   task t_sticky;
      csr_write(16'h1F80);
      masked(OP_SQRT, 3'h0, 32'hC000_0000, ONE, ONE, 1'h0, QNAN_INDEF, 1'h1);
      do_op(OP_ADD, 3'h0, ONE, ONE, ONE, 5'h00, 1'h0);
      chk("csr", 32'h0000_1F81, {16'h0000, csr});
      csr_write(16'hFFFF);
      csr_write(16'h9FC0);
      masked(OP_ADD, 3'h0, INF, NINF, ONE, 1'h0, QNAN_INDEF, 1'h1);
   endtask

   // op and csr load offered while the clock enable is low must leave all state alone
   task t_hold;
      logic [15:0] keep;
      keep = csr;
      @(posedge clk_sys);
      ce <= 1'h0;
      csr_wr <= 1'h1;
      wdata <= 16'h0000;
      op <= OP_SQRT;
      src1 <= 32'hC000_0000;
      op_valid <= 1'h1;
      repeat (3) @(posedge clk_sys);
      op_valid <= 1'h0;
      csr_wr <= 1'h0;
      ce <= 1'h1;
      #1;
      chkb("done", 1'h0, done);
      chk("csr", {16'h0000, keep}, {16'h0000, csr});
      chk("exc", 32'h0000_0000, {26'h000_0000, exc});
      do_op(OP_ADD, 3'h0, ONE, ONE, ONE, 5'h00, 1'h0);
      chk("csr", {16'h0000, keep}, {16'h0000, csr});
   endtask

   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'h1;
      @(posedge clk_sys);
      #1;
      t_reset();
      t_masked_table();
      t_compare();
      t_unmasked();
      t_sticky();
      t_hold();
      report_and_stop();
   end
endmodule
